// ### inc/pds_pkg.sv
// Package for the diagnostic conversion scheduler: register map, fields, types
`default_nettype none
package pds_pkg;
  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam int QDEPTH = 8;
  localparam int QIDX_W = 4;
  localparam int RES_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************************************
  // Register map (byte offsets, one word apart, on the plain register port)
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_SETUP_BASE = 8'h40;
  localparam logic [7:0] OFS_RESULT_BASE = 8'h80;
  localparam logic [7:0] OFS_QUEUE_BASE = 8'hc0;
  localparam logic [7:0] OFS_BLOCK_MASK = 8'hc0;

  // Control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_STORE_BIT = 1;
  // Status fields
  localparam int STAT_NE_BIT = 0;
  localparam int STAT_FULL_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;

  // ****************************************************************
  // Per-channel conversion setup layout
  // ****************************************************************
  typedef struct packed {
    logic [13:0] wait_time;   // [29:16]
    logic [2:0] limit_sel;    // [15:13]
    logic [3:0] mux_addr;     // [12:9]
    logic mux_en;             // [8]
    logic [5:0] phys_input;   // [7:2]
    logic [1:0] unit_sel;     // [1:0]
  } pds_setup_t;
  localparam int SETUP_W = $bits(pds_setup_t);
  localparam logic [SETUP_W-1:0] SETUP_RESET = '0;

  // Converter request bundle
  typedef struct packed {
    logic trig;
    logic [CH_W-1:0] chan;
    pds_setup_t setup;
  } pds_conv_req_t;

  // Register port request bundle
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pds_bus_req_t;
endpackage
`default_nettype wire

// ### rtl/pds_scheduler.sv
// Diagnostic conversion scheduler: trigger queue, converter hand-off, results
`default_nettype none

module pds_scheduler #(
  parameter int NUM_CH = pds_pkg::NUM_CH,
  parameter int QDEPTH = pds_pkg::QDEPTH
) (
  input wire logic i_clk,                                 // System clock
  input wire logic i_rst_n,                               // Sync reset, low
  input wire logic [NUM_CH-1:0] i_pwm_channel_trigger,    // Channel trigger pulses
  input wire logic i_conversion_end_pulse,                // Conversion done pulse
  input wire logic [pds_pkg::RES_W-1:0] i_conv_result,    // Converter result
  input wire pds_pkg::pds_bus_req_t i_bus,                // Register port request
  output logic [pds_pkg::DATA_W-1:0] o_rdata,             // Read data, next cycle
  output pds_pkg::pds_conv_req_t o_conv,                  // Trigger, channel, setup
  output logic o_queue_not_empty_flag,                    // Queue holds entries
  output logic o_queue_full_flag,                         // Slot 7 occupied
  output logic o_queue_full_irq                           // One-cycle full pulse
);
  localparam int CW = pds_pkg::CH_W;
  localparam int QW = pds_pkg::QIDX_W;
  localparam logic [QW-1:0] QD = QW'(QDEPTH);

  typedef enum logic [0:0] {S_IDLE, S_BUSY} pds_state_t;

  // All state of the block
  typedef struct packed {
    pds_state_t state;
    logic enable;
    logic store_en;
    logic [QDEPTH-1:0][CW-1:0] queue;
    logic [QW-1:0] count;
    logic [NUM_CH-1:0][pds_pkg::SETUP_W-1:0] setup;
    logic [NUM_CH-1:0][pds_pkg::RES_W-1:0] result;
    pds_pkg::pds_conv_req_t conv;
    logic ne;
    logic full;
    logic irq;
    logic [pds_pkg::DATA_W-1:0] rdata;
  } pds_regs_t;

  pds_regs_t s_reg;
  pds_regs_t s_next;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    logic shift;
    logic [QW-1:0] cnt;
    logic [pds_pkg::ADDR_W-1:0] a;
    logic [CW-1:0] idx;
    shift = 1'b0;
    cnt = '0;
    a = '0;
    idx = '0;
    s_next = s_reg;
    s_next.conv.trig = 1'b0;
    s_next.irq = 1'b0;
    s_next.rdata = '0;

    // End pulse: optional store, then drop head
    shift = i_conversion_end_pulse && (s_reg.state == S_BUSY);
    if (shift) begin
      if (s_reg.store_en) begin
        s_next.result[s_reg.conv.chan] = i_conv_result;
      end
      for (int j = 0; j < QDEPTH - 1; j++) begin
        s_next.queue[j] = s_reg.queue[j+1];
      end
      s_next.queue[QDEPTH-1] = '0;
    end
    cnt = shift ? s_reg.count - QW'(1) : s_reg.count;

    // Triggers in ascending order; full queue drops them
    // Counting from the post-shift fill lets an end pulse free slot 7 for a
    // trigger arriving in that very cycle, instead of losing it
    if (s_reg.enable) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (i_pwm_channel_trigger[c]) begin
          if (cnt >= QD) begin
            s_next.irq = 1'b1;
          end else begin
            s_next.queue[cnt[QW-2:0]] = CW'(c);
            if (cnt == QD - QW'(1)) begin
              s_next.irq = 1'b1;
            end
            cnt = cnt + QW'(1);
          end
        end
      end
    end
    s_next.count = cnt;
    s_next.ne = (cnt != '0);
    s_next.full = (cnt == QD);

    // Converter hand-off; one conversion outstanding at a time
    case (s_reg.state)
      S_IDLE: begin
        if (s_reg.enable && cnt != '0) begin
          s_next.state = S_BUSY;
        end
      end
      S_BUSY: begin
        if (shift) begin
          // Stay busy while entries remain so the next trigger follows the end pulse
          s_next.state = (s_reg.enable && cnt != '0) ? S_BUSY : S_IDLE;
        end
      end
      default: s_next.state = S_IDLE;
    endcase
    if (s_next.state == S_BUSY && (s_reg.state == S_IDLE || shift)) begin
      // Head after shift and enqueue drives trigger and setup together
      s_next.conv.trig = 1'b1;
      s_next.conv.chan = s_next.queue[0];
      s_next.conv.setup = s_reg.setup[s_next.queue[0]];
    end

    // Register writes
    a = i_bus.addr;
    idx = CW'(a[pds_pkg::ADDR_W-3:2]);
    if (i_bus.wr) begin
      if (a == pds_pkg::OFS_CTRL) begin
        s_next.enable = i_bus.wdata[pds_pkg::CTRL_ENABLE_BIT];
        s_next.store_en = i_bus.wdata[pds_pkg::CTRL_STORE_BIT];
      end else if ((a & pds_pkg::OFS_BLOCK_MASK) == pds_pkg::OFS_SETUP_BASE &&
                   int'(a[pds_pkg::ADDR_W-3:2]) < NUM_CH) begin
        s_next.setup[idx] = i_bus.wdata[pds_pkg::SETUP_W-1:0];
      end
    end
    // Register reads, data one cycle later; unmapped reads zero
    if (i_bus.rd) begin
      if (a == pds_pkg::OFS_CTRL) begin
        s_next.rdata[pds_pkg::CTRL_ENABLE_BIT] = s_reg.enable;
        s_next.rdata[pds_pkg::CTRL_STORE_BIT] = s_reg.store_en;
      end else if (a == pds_pkg::OFS_STATUS) begin
        s_next.rdata[pds_pkg::STAT_NE_BIT] = s_reg.ne;
        s_next.rdata[pds_pkg::STAT_FULL_BIT] = s_reg.full;
        s_next.rdata[pds_pkg::STAT_BUSY_BIT] = (s_reg.state == S_BUSY);
      end else if (int'(a[pds_pkg::ADDR_W-3:2]) < NUM_CH) begin
        case (a & pds_pkg::OFS_BLOCK_MASK)
          pds_pkg::OFS_SETUP_BASE: s_next.rdata[pds_pkg::SETUP_W-1:0] = s_reg.setup[idx];
          pds_pkg::OFS_RESULT_BASE: s_next.rdata[pds_pkg::RES_W-1:0] = s_reg.result[idx];
          pds_pkg::OFS_QUEUE_BASE: s_next.rdata[CW-1:0] = s_reg.queue[idx];
          default: s_next.rdata = '0;
        endcase
      end
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset wipes queue, flags and trigger; results cleared too for determinism
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_reg <= '0;
      s_reg.state <= S_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from flops
  assign o_rdata = s_reg.rdata;
  assign o_conv = s_reg.conv;
  assign o_queue_not_empty_flag = s_reg.ne;
  assign o_queue_full_flag = s_reg.full;
  assign o_queue_full_irq = s_reg.irq;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Checks watch registered state and the inputs sampled at each edge, so they see settled values each edge;
  // while reset is low they are switched off unless a check says otherwise
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  setup_hold_a: assert property (!o_conv.trig ##1 !o_conv.trig |->
    $stable(o_conv.setup)) else $error("setup changed without trigger");
  trig_head_a: assert property (o_conv.trig |->
    o_conv.chan == s_reg.queue[0]) else $error("trigger not on head");
  ne_flag_a: assert property (o_queue_not_empty_flag ==
    (s_reg.count != '0)) else $error("not-empty flag wrong");
  full_flag_a: assert property (o_queue_full_flag ==
    (s_reg.count == QD)) else $error("full flag wrong");
  full_keep_a: assert property (o_queue_full_flag && !i_conversion_end_pulse
    |=> $stable(s_reg.queue)) else $error("full queue changed");
  shift_down_a: assert property (i_conversion_end_pulse && s_reg.state == S_BUSY
    && i_pwm_channel_trigger == '0 |=>
    s_reg.count == $past(s_reg.count) - QW'(1)) else $error("shift count wrong");
  next_conv_a: assert property (i_conversion_end_pulse && s_reg.state == S_BUSY
    && s_reg.count > QW'(1) && s_reg.enable |=> o_conv.trig)
    else $error("no next trigger");
  disabled_a: assert property (!s_reg.enable && s_reg.state == S_IDLE
    |=> !o_conv.trig) else $error("trigger while disabled");
  full_irq_a: assert property (s_reg.enable && o_queue_full_flag &&
    (|i_pwm_channel_trigger) |=> o_queue_full_irq) else $error("no full irq");
  store_off_a: assert property (!s_reg.store_en |=>
    $stable(s_reg.result)) else $error("result stored while disabled");

  // ****************************************************************
  // Reset, status and register port checks
  // ****************************************************************
  // Reset check keeps its own empty disable so it is live while reset is low
  reset_clear_a: assert property (disable iff (1'b0) !i_rst_n |=>
    s_reg.count == '0 && !o_conv.trig && !o_queue_not_empty_flag && !o_queue_full_flag)
    else $error("reset left state behind");

  // Occupancy never passes the depth, even with every trigger at once
  count_bound_a: assert property (s_reg.count <= QD)
    else $error("queue count beyond depth");

  // Idle, empty and enabled: a trigger starts a conversion one cycle later
  first_trig_a: assert property (s_reg.enable && s_reg.state == S_IDLE &&
    s_reg.count == '0 && (|i_pwm_channel_trigger) |=> o_conv.trig)
    else $error("no trigger from idle");

  // Two simultaneous triggers into an empty queue land lowest channel first
  order_pair_a: assert property (s_reg.enable && s_reg.count == '0 &&
    i_pwm_channel_trigger == NUM_CH'(3) |=>
    s_reg.queue[0] == CW'(0) && s_reg.queue[1] == CW'(1))
    else $error("simultaneous triggers out of order");

  // Any accepted trigger leaves the not-empty flag set
  ne_set_a: assert property (s_reg.enable && !o_queue_full_flag &&
    (|i_pwm_channel_trigger) |=> o_queue_not_empty_flag)
    else $error("not-empty flag missed an enqueue");

  // The trigger that fills the last slot raises the full flag
  full_set_a: assert property (s_reg.enable && s_reg.count == QD - QW'(1) &&
    (|i_pwm_channel_trigger) && !i_conversion_end_pulse |=> o_queue_full_flag)
    else $error("full flag not set");

  // A shift with no new trigger frees slot 7 and drops the full flag
  full_clr_a: assert property (o_queue_full_flag && i_conversion_end_pulse &&
    s_reg.state == S_BUSY && i_pwm_channel_trigger == '0 |=> !o_queue_full_flag)
    else $error("full flag not cleared");

  // Read data stand only in the cycle after a read strobe
  rdata_idle_a: assert property (!i_bus.rd |=> o_rdata == '0)
    else $error("read data without a read");

  // ****************************************************************
  // Queue data checks
  // ****************************************************************
  // With storing on, the end pulse lands the result in the converted channel
  store_on_a: assert property (s_reg.store_en && i_conversion_end_pulse &&
    s_reg.state == S_BUSY |=>
    s_reg.result[$past(o_conv.chan)] == $past(i_conv_result))
    else $error("result not stored");

  // The second entry becomes the head after a shift
  shift_head_a: assert property (i_conversion_end_pulse && s_reg.state == S_BUSY &&
    s_reg.count > QW'(1) |=> s_reg.queue[0] == $past(s_reg.queue[1]))
    else $error("head not shifted");

  // The channel number toward the converter moves only with a trigger
  chan_hold_a: assert property (!o_conv.trig |-> $stable(o_conv.chan))
    else $error("channel changed without trigger");

  // A stray end pulse with nothing outstanding leaves the queue alone
  end_idle_a: assert property (i_conversion_end_pulse && s_reg.state == S_IDLE &&
    i_pwm_channel_trigger == '0 |=> $stable(s_reg.count))
    else $error("idle end pulse changed queue");

  // The full interrupt only ever answers an accepted-time trigger
  irq_cause_a: assert property (o_queue_full_irq |->
    $past(|i_pwm_channel_trigger) && $past(s_reg.enable))
    else $error("full irq without trigger");

  // Main scenarios that the bench is expected to reach

  fill_c: cover property (o_queue_full_flag ##1 !o_queue_full_flag);
  pair_c: cover property (s_reg.enable && $countones(i_pwm_channel_trigger) > 1);
  drain_c: cover property (o_queue_not_empty_flag ##1 !o_queue_not_empty_flag);
  both_c: cover property (i_conversion_end_pulse && (|i_pwm_channel_trigger));
  next_c: cover property (i_conversion_end_pulse && s_reg.count > QW'(1) ##1 o_conv.trig);
endmodule
`default_nettype wire

// ### testbench/pds_conv_model.sv
// Converter partner model: one end pulse and one result per scheduler trigger
`default_nettype none
module pds_conv_model #(
  parameter logic [15:0] LIMIT_HI = 16'hd5ad
) (
  input wire logic i_clk,                       // Clock
  input wire logic i_rst_n,                     // Sync reset, low
  input wire logic i_hw_trigger_enable,         // Trigger gate
  input wire logic [31:0] i_lat,                // Cycles per conversion, less one
  input wire pds_pkg::pds_conv_req_t i_conv,    // Request from scheduler
  output logic o_conversion_end_pulse,          // One-cycle done
  output logic [15:0] o_conv_result,            // Valid with done only
  output logic [29:0] o_active_virtual_channel, // Setup under conversion
  output logic o_limit_error_irq                // Result above limit
);
  timeunit 1ns;
  timeprecision 100ps;
  logic busy;
  logic [31:0] cnt;
  logic [2:0] ch;
  // ****************************************************************
  // Conversion timer
  // ****************************************************************
  // Result line toggles outside the done cycle so a stale value never passes
  always_ff @(posedge i_clk) begin
    o_conversion_end_pulse <= 1'b0;
    o_limit_error_irq <= 1'b0;
    o_conv_result <= ~o_conv_result;
    if (!i_rst_n) begin
      busy <= 1'b0;
      o_conv_result <= 16'h0000;
      o_active_virtual_channel <= '0;
    end else if (i_conv.trig && i_hw_trigger_enable) begin
      busy <= 1'b1;
      cnt <= i_lat;
      ch <= i_conv.chan;
      o_active_virtual_channel <= i_conv.setup;
    end else if (busy) begin
      cnt <= cnt - 32'h1;
      if (cnt == 32'h0) begin
        busy <= 1'b0;
        o_conversion_end_pulse <= 1'b1;
        o_conv_result <= {13'h1ab5, ch};
        o_limit_error_irq <= ({13'h1ab5, ch} > LIMIT_HI);
      end
    end
  end
endmodule
`default_nettype wire

// ### testbench/pds_scheduler_bench.sv
// Self-checking bench for the diagnostic conversion scheduler
`default_nettype none
module pds_scheduler_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] trg = 8'h00;
  logic [31:0] lat = 32'h14;
  pds_pkg::pds_bus_req_t bus = '0;
  pds_pkg::pds_conv_req_t conv;
  logic [31:0] rdata;
  logic [29:0] avc;
  logic [15:0] res;
  logic ne, full, irq, endp, lim;
  int n_fail = 0;
  int samples_checked = 0;
  logic [2:0] got[$];
  logic [2:0] exp_q[$];
  always #4 clk = ~clk;
  pds_scheduler dut (.i_clk(clk), .i_rst_n(rst_n), .i_pwm_channel_trigger(trg),
    .i_conversion_end_pulse(endp), .i_conv_result(res), .i_bus(bus), .o_rdata(rdata),
    .o_conv(conv), .o_queue_not_empty_flag(ne), .o_queue_full_flag(full),
    .o_queue_full_irq(irq));
  pds_conv_model far (.i_clk(clk), .i_rst_n(rst_n), .i_hw_trigger_enable(1'b1), .i_lat(lat),
    .i_conv(conv), .o_conversion_end_pulse(endp), .o_conv_result(res),
    .o_active_virtual_channel(avc), .o_limit_error_irq(lim));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [29:0] sv(input logic [2:0] c);
    return {11'h2c5, c, 13'h0a5a, c};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Bus and trigger drivers leave one idle cycle so no strobe is set twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    bus <= '0;
    #1 check(nm, rdata, ex);
    @(posedge clk);
  endtask
  task automatic pulse(input logic [7:0] m, input logic e_irq);
    trg <= m;
    @(posedge clk);
    trg <= 8'h00;
    #1 check("irq", 32'(irq), 32'(e_irq));
    @(posedge clk);
  endtask
  // Wait for the queue to empty, then compare the conversion order
  task automatic drain;
    int i;
    for (i = 0; i < 2000 && ne !== 1'b0; i++) @(negedge clk);
    if (ne !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end
    @(posedge clk);
    check("count", 32'(got.size()), 32'(exp_q.size()));
    foreach (exp_q[k]) check("order", 32'(got[k]), 32'(exp_q[k]));
    got.delete();
    exp_q.delete();
  endtask
  // Log each conversion start away from the launching edge
  always @(negedge clk) begin
    if (conv.trig === 1'b1) begin
      got.push_back(conv.chan);
      check("setup", 32'(conv.setup), 32'(sv(conv.chan)));
    end
  end
  initial begin
    int c;
    repeat (12) @(posedge clk);
    check("idle", 32'({conv.trig, ne, full, irq}), 32'h0);
    rst_n <= 1'b1;
    @(posedge clk);
    rd("status", pds_pkg::OFS_STATUS, 32'h0);
    for (c = 0; c < 8; c++) wr(pds_pkg::OFS_SETUP_BASE + 8'(4 * c), 32'(sv(3'(c))));
    rd("setup5", pds_pkg::OFS_SETUP_BASE + 8'h14, 32'(sv(3'd5)));
    rd("unmapped", 8'h08, 32'h0);
    // Disabled block ignores triggers
    pulse(8'h01, 1'b0);
    repeat (4) @(posedge clk);
    check("disabled", 32'({got.size() != 0, ne}), 32'h0);
    wr(pds_pkg::OFS_CTRL, 32'h3);
    // Two channels at once, lower number first
    pulse(8'h03, 1'b0);
    rd("status", pds_pkg::OFS_STATUS, 32'h5);
    exp_q = '{3'd0, 3'd1};
    drain();
    rd("result0", pds_pkg::OFS_RESULT_BASE, {16'h0, 13'h1ab5, 3'd0});
    rd("result1", pds_pkg::OFS_RESULT_BASE + 8'h04, {16'h0, 13'h1ab5, 3'd1});
    check("avc", 32'(avc), 32'(sv(3'd1)));
    rd("status", pds_pkg::OFS_STATUS, 32'h0);
    // Store disabled leaves the result untouched
    wr(pds_pkg::OFS_CTRL, 32'h1);
    pulse(8'h08, 1'b0);
    exp_q = '{3'd3};
    drain();
    rd("result3", pds_pkg::OFS_RESULT_BASE + 8'h0c, 32'h0);
    // Fill, overflow, then refill the last slot after one shift
    lat <= 32'd60;
    pulse(8'hff, 1'b1);
    rd("status", pds_pkg::OFS_STATUS, 32'h7);
    pulse(8'h20, 1'b1);
    for (c = 0; c < 8; c++) rd("queue", pds_pkg::OFS_QUEUE_BASE + 8'(4 * c), 32'(c));
    for (c = 0; c < 200 && full !== 1'b0; c++) @(negedge clk);
    check("fullclr", 32'({full, ne}), 32'h1);
    @(posedge clk);
    pulse(8'h04, 1'b1);
    for (c = 0; c < 8; c++) exp_q.push_back(3'(c));
    exp_q.push_back(3'd2);
    drain();
    report_and_stop();
  end
endmodule
`default_nettype wire
